// ---- testbench/fpe_panel_model.sv ----
`timescale 1ns/100ps
// knob operator and settings memory on the far side of the panel logic
module fpe_panel_model
	import fpe_pkg::*;
(
	input wire logic ref_clk, // system clock
	input wire logic nv_rd, // memory read strobe
	input wire logic nv_we, // memory write strobe
	input wire logic [4:0] nv_addr, // word address
	input wire logic [7:0] nv_wdata, // write data
	output logic [7:0] nv_rdata, // read data
	output logic enc_a_pin, // encoder phase a
	output logic enc_b_pin, // encoder phase b
	output logic enc_push_pin // knob push, high when pressed
);
	logic [7:0] mem [0:21]; // stored image
	int wcount = 0; // words written so far
	initial
	begin
		foreach (mem[i]) mem[i] = 8'h00;
		nv_rdata = 8'h00;
		enc_a_pin = 1'b0;
		enc_b_pin = 1'b0;
		enc_push_pin = 1'b0;
	end
	// idle data flips each cycle, so a late sample never looks right
	always @(posedge ref_clk)
	begin
		nv_rdata <= nv_rd ? mem[nv_addr] : ~nv_rdata;
		if (nv_we)
		begin
			mem[nv_addr] <= nv_wdata;
			wcount <= wcount + 1;
		end
	end
	// one detent: b picks direction, then a rises
	task automatic turn(input logic cw);
		@(negedge ref_clk);
		enc_b_pin = ~cw;
		repeat (2) @(negedge ref_clk);
		enc_a_pin = 1'b1;
		repeat (5) @(negedge ref_clk);
		enc_a_pin = 1'b0;
		repeat (5) @(negedge ref_clk);
	endtask : turn
	// hold the knob down for cyc cycles, then let it settle
	task automatic press(input int cyc);
		@(negedge ref_clk);
		enc_push_pin = 1'b1;
		repeat (cyc) @(negedge ref_clk);
		enc_push_pin = 1'b0;
		repeat (12) @(negedge ref_clk);
	endtask : press
endmodule : fpe_panel_model

// ---- testbench/tb_top.sv ----
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
	import fpe_pkg::*;
	logic ref_clk, reset, host_inst_we, store_req;
	logic store_midi_en, midi_ready;
	logic [6:0] host_inst_val;
	logic enc_a_pin, enc_b_pin, enc_push_pin, nv_rd, nv_we, mode_led;
	logic [4:0] nv_addr, gain_idx, l_idx;
	logic [7:0] nv_rdata, nv_wdata, disp_char_hi, disp_char_lo, cfg_io, midi_byte, io;
	logic disp_dot_hi, disp_dot_lo, gain_we, cfg_master, gang_on, midi_valid;
	logic [6:0] mic_gain_1, mic_gain_2, inst_gain, gain_val, l_val;
	logic [2:0] cfg_rate;
	logic [7:0] mq [$]; // midi bytes taken
	int errors = 0, checks = 0, n_we = 0, k, n;
	wire [15:0] chars = {disp_char_hi, disp_char_lo}; // shown text
	wire [16:0] shown = {chars, disp_dot_hi}; // text and left dot
	// short counts keep press timing within a few dozen cycles
	fpe_front_panel #(.DEBOUNCE_CYC(4), .LONG_CYC(50)) fpe_front_panel_inst (
		.ref_clk(ref_clk), .reset(reset), .enc_a_pin(enc_a_pin), .enc_b_pin(enc_b_pin),
		.enc_push_pin(enc_push_pin), .host_inst_we(host_inst_we),
		.host_inst_val(host_inst_val), .store_req(store_req),
		.store_midi_en(store_midi_en), .nv_rdata(nv_rdata), .nv_rd(nv_rd), .nv_we(nv_we),
		.nv_addr(nv_addr), .nv_wdata(nv_wdata), .mode_led(mode_led),
		.disp_char_hi(disp_char_hi), .disp_char_lo(disp_char_lo),
		.disp_dot_hi(disp_dot_hi), .disp_dot_lo(disp_dot_lo), .mic_gain_1(mic_gain_1),
		.mic_gain_2(mic_gain_2), .inst_gain(inst_gain), .gain_we(gain_we),
		.gain_idx(gain_idx), .gain_val(gain_val), .cfg_rate(cfg_rate),
		.cfg_master(cfg_master), .cfg_io(cfg_io), .gang_on(gang_on),
		.midi_valid(midi_valid), .midi_byte(midi_byte), .midi_ready(midi_ready));
	fpe_panel_model fpe_panel_model_inst (.ref_clk(ref_clk), .nv_rd(nv_rd), .nv_we(nv_we),
		.nv_addr(nv_addr), .nv_wdata(nv_wdata), .nv_rdata(nv_rdata),
		.enc_a_pin(enc_a_pin), .enc_b_pin(enc_b_pin), .enc_push_pin(enc_push_pin));
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// record parameter writes and accepted midi bytes
	always @(posedge ref_clk)
	begin
		if (gain_we === 1'b1)
		begin
			l_idx <= gain_idx;
			l_val <= gain_val;
			n_we <= n_we + 1;
		end
		if (midi_valid === 1'b1 && midi_ready)
			mq.push_back(midi_byte);
	end
	// a transmitter that stalls at random
	always @(negedge ref_clk) midi_ready <= 1'($urandom % 2);
	// channel label and left dot expected for a select entry
	function automatic logic [16:0] lab(input int i);
		if (i < 4) return {FPE_CHAR_IN, 8'h31 + 8'(i), 1'b1};
		if (i < 10) return {FPE_CHAR_LINE, 8'h31 + 8'(i - 4), 1'b1};
		if (i == 10) return {FPE_HEADPHONE_PAIR_LABEL, 1'b0};
		if (i == 11) return {FPE_COAX_DIGITAL_OUT_LABEL, 1'b0};
		return {FPE_CHAR_OPT, 8'h31 + 8'(i - 12), 1'b1};
	endfunction : lab
	// two decimal digits
	function automatic logic [15:0] dig(input int v);
		return {8'h30 + 8'(v / 10), 8'h30 + 8'(v % 10)};
	endfunction : dig
	task automatic rst();
		reset = 1'b1;
		repeat (12) @(negedge ref_clk);
		reset = 1'b0;
		repeat (30) @(negedge ref_clk);
	endtask : rst
	// leave level mode, move m entries clockwise, come back
	task automatic goto(input int m);
		fpe_panel_model_inst.press(10);
		repeat (m) fpe_panel_model_inst.turn(1'b1);
		fpe_panel_model_inst.press(10);
	endtask : goto
	task automatic pulse(ref logic s);
		@(negedge ref_clk);
		s = 1'b1;
		@(negedge ref_clk);
		s = 1'b0;
		repeat (30) @(negedge ref_clk);
	endtask : pulse
	task automatic print_verdict();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict
	initial
	begin
		reset = 1'b1;
		host_inst_we = 1'b0;
		store_req = 1'b0;
		store_midi_en = 1'b0;
		host_inst_val = 7'h00;
		void'($urandom(32'hdcd9));
		io = 8'($urandom);
		#1;
		fpe_panel_model_inst.mem[0] = 8'h0d;
		fpe_panel_model_inst.mem[1] = io;
		fpe_panel_model_inst.mem[2] = 8'h37;
		fpe_panel_model_inst.mem[3] = 8'h01;
		fpe_panel_model_inst.mem[4] = 8'h03;
		rst();
		`CHK(cfg_rate, 3'h5)
		`CHK(cfg_master, 1'b1)
		`CHK(cfg_io, io)
		`CHK(mic_gain_1, 7'h37)
		`CHK(inst_gain, 7'h03)
		$display("test load done");
		for (int i = 1; i <= 20; i++)
		begin
			fpe_panel_model_inst.turn(1'b1);
			`CHK(shown, lab(i % 20))
		end
		fpe_panel_model_inst.turn(1'b0);
		`CHK(shown, lab(19))
		fpe_panel_model_inst.turn(1'b1);
		$display("test select done");
		fpe_panel_model_inst.press(10);
		`CHK(mode_led, 1'b1)
		repeat (2) fpe_panel_model_inst.turn(1'b1);
		`CHK(mic_gain_1, FPE_MIC_MAX)
		`CHK(chars, dig(65))
		goto(1);
		repeat (3) fpe_panel_model_inst.turn(1'b0);
		`CHK(mic_gain_2, 7'h00)
		`CHK(chars, dig(0))
		goto(1);
		fpe_panel_model_inst.turn(1'b0);
		`CHK({chars, disp_dot_lo}, {dig(1), 1'b0})
		fpe_panel_model_inst.turn(1'b0);
		`CHK({chars, disp_dot_lo}, {dig(0), 1'b1})
		repeat (2) fpe_panel_model_inst.turn(1'b0);
		`CHK(inst_gain, 7'h00)
		goto(1);
		fpe_panel_model_inst.turn(1'b1);
		`CHK(l_idx, FPE_INST_IDX)
		host_inst_val = 7'h28;
		pulse(host_inst_we);
		`CHK(inst_gain, FPE_INST_MAX)
		$display("test gain done");
		goto(1);
		`CHK(chars, {FPE_CHAR_DASH, FPE_CHAR_DASH})
		fpe_panel_model_inst.turn(1'b0);
		`CHK(l_val, 7'h00)
		fpe_panel_model_inst.turn(1'b1);
		`CHK(shown, {dig(58), 1'b1})
		k = 1 + int'($urandom % 8);
		repeat (k) fpe_panel_model_inst.turn(1'b1);
		`CHK(l_val, 7'(1 + k))
		fpe_panel_model_inst.press(60);
		`CHK(gang_on, 1'b1)
		`CHK(chars, {FPE_CHAR_O, FPE_CHAR_N})
		`CHK(mode_led, 1'b1)
		n = n_we;
		fpe_panel_model_inst.turn(1'b1);
		`CHK(n_we - n, 2)
		`CHK(l_idx, 5'h05)
		fpe_panel_model_inst.press(10);
		fpe_panel_model_inst.turn(1'b1);
		`CHK(shown, lab(6))
		$display("test gang done");
		store_midi_en = 1'b1;
		pulse(store_req);
		`CHK(fpe_panel_model_inst.wcount, 22)
		`CHK(fpe_panel_model_inst.mem[0][5:4], 2'b11)
		`CHK(fpe_panel_model_inst.mem[2][6:0], FPE_MIC_MAX)
		rst();
		`CHK(mic_gain_1, FPE_MIC_MAX)
		`CHK(gang_on, 1'b1)
		n = n_we;
		fpe_panel_model_inst.turn(1'b1);
		for (int w = 0; w < 200 && mq.size() < 3; w++) @(negedge ref_clk);
		if (mq.size() < 3)
		begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, mq.size(), 3);
		end
		else
		begin
			`CHK(mq[0], FPE_NOTE_ON)
			`CHK(mq[1], FPE_NOTE_CW)
			`CHK(mq[2], FPE_NOTE_VEL)
		end
		`CHK(n_we, n)
		$display("test midi done");
		print_verdict();
	end
endmodule : tb_top

// ---- verilog/fpe_front_panel.sv ----
`timescale 1ns/100ps
module fpe_front_panel
	import fpe_pkg::*;
#(
	parameter int DEBOUNCE_CYC = fpe_pkg::FPE_DEBOUNCE_CYC, // button settle time
	parameter int LONG_CYC = fpe_pkg::FPE_LONG_CYC // long press hold time
)
(
	input wire logic ref_clk, // system clock
	input wire logic reset, // synchronous, active high
	input wire logic enc_a_pin, // encoder phase a
	input wire logic enc_b_pin, // encoder phase b
	input wire logic enc_push_pin, // knob push, high when pressed
	input wire logic host_inst_we, // host writes instrument gain
	input wire logic [6:0] host_inst_val, // instrument gain code from host
	input wire logic store_req, // save current state to memory
	input wire logic store_midi_en, // midi control flag of saved state
	input wire logic [7:0] nv_rdata, // memory data, cycle after nv_rd
	output logic nv_rd, // memory read strobe
	output logic nv_we, // memory write strobe
	output logic [4:0] nv_addr, // memory word address
	output logic [7:0] nv_wdata, // memory write data
	output logic mode_led, // green led, lit in level mode
	output logic [7:0] disp_char_hi, // left display character
	output logic [7:0] disp_char_lo, // right display character
	output logic disp_dot_hi, // dot after left character
	output logic disp_dot_lo, // dot after right character
	output logic [6:0] mic_gain_1, // preamp gain code, input 1
	output logic [6:0] mic_gain_2, // preamp gain code, input 2
	output logic [6:0] inst_gain, // gain code, inputs 3 and 4
	output logic gain_we, // parameter update strobe to mixer
	output logic [4:0] gain_idx, // channel entry being updated
	output logic [6:0] gain_val, // new gain or level code
	output logic [2:0] cfg_rate, // stored sample rate code
	output logic cfg_master, // stored clock master selection
	output logic [7:0] cfg_io, // stored channel and i/o setup
	output logic gang_on, // stereo gang mode
	output logic midi_valid, // midi byte offered
	output logic [7:0] midi_byte, // midi byte
	input wire logic midi_ready // midi transmitter takes the byte
);
	typedef struct packed {
		fpe_state_t state; // load, run or store
		logic a1, a2, ap, b1, b2, p1, p2; // pin synchronisers and history
		logic btn; // debounced button
		logic [26:0] db_cnt; // settle counter
		logic [26:0] hold; // press duration
		logic long_done; // long action taken for this press
		logic level_mode; // 0 channel mode, 1 level mode
		logic gang; // stereo gang mode
		logic gang_show; // display shows on/off
		logic [4:0] sel; // selected channel entry
		logic [4:0] cnt; // image word counter
		logic [4:0] cnt_d; // word whose data arrives now
		logic rd_d; // data of cnt_d valid now
		logic nv_rd, nv_we; // memory strobes
		logic [4:0] nv_addr; // memory address
		logic [7:0] nv_wdata; // memory write data
		logic [7:0] cfg0, cfg_io; // configuration words
		logic ram_we; // parameter store write
		logic [4:0] ram_waddr; // parameter store slot
		logic [6:0] ram_wdata; // parameter store data
		logic pend; // partner write due
		logic [6:0] pend_val; // value for the partner
		logic [6:0] mic1, mic2, inst; // analog gain codes
		logic gain_we; // mixer update strobe
		logic [4:0] gain_idx; // mixer entry
		logic [6:0] gain_val; // mixer code
		logic [7:0] ch_hi, ch_lo; // display characters
		logic dot_hi, dot_lo; // display dots
		logic midi_valid; // midi byte offered
		logic [7:0] midi_byte; // midi byte
		logic [1:0] midi_cnt; // bytes left in the message
		logic [7:0] midi_note; // note of the message
	} fpe_regs_t;

	fpe_regs_t st; // registered state
	fpe_regs_t next_st; // next state
	logic [4:0] raddr; // parameter store read slot
	logic [6:0] rdata; // parameter store read data

	// inputs 3/4 share one slot, so both entries resolve to it
	function automatic logic [4:0] ch_addr(input logic [4:0] s);
		ch_addr = (s == FPE_INST_ALT) ? FPE_INST_IDX : s;
	endfunction : ch_addr

	// highest code per channel class
	function automatic logic [6:0] max_of(input logic [4:0] a);
		if (a < FPE_INST_IDX)
			max_of = FPE_MIC_MAX;
		else if (a < FPE_LINE_FIRST)
			max_of = FPE_INST_MAX;
		else
			max_of = FPE_OUT_MAX;
	endfunction : max_of

	// left channel of a real pair; phones and coax are single entries already
	function automatic logic has_partner(input logic [4:0] s);
		has_partner = !s[0] && (s != FPE_INST_IDX) && (s != FPE_PHONES_SEL);
	endfunction : has_partner

	// one step through the list, skipping right channels under gang
	function automatic logic [4:0] next_ch(input logic [4:0] s, input logic cw,
		input logic g);
		logic [4:0] t;
		t = s;
		for (int i = 0; i < 2; i++)
		begin
			if (i == 0 || (g && t[0] && t != FPE_COAX_SEL))
			begin
				if (cw)
					t = (t == FPE_CH_LAST) ? 5'h00 : 5'(t + 5'h01);
				else
					t = (t == 5'h00) ? FPE_CH_LAST : 5'(t - 5'h01);
			end
		end
		next_ch = t;
	endfunction : next_ch

	// ascii digit
	function automatic logic [7:0] dig(input logic [6:0] v);
		dig = FPE_CHAR_ZERO + {1'b0, v};
	endfunction : dig

	// store reads the image sequentially, otherwise the selected channel
	assign raddr = (st.state == FPE_STORE) ? 5'(st.cnt - FPE_NV_CH_BASE) : ch_addr(st.sel);

	fpe_param_ram u_ram (
		.ref_clk(ref_clk),
		.we(st.ram_we),
		.waddr(st.ram_waddr),
		.wdata(st.ram_wdata),
		.raddr(raddr),
		.rdata(rdata)
	);

	// all control decisions of one cycle
	always_comb
	begin
		logic short_ev, long_ev, step, cw, wr;
		logic [4:0] wa, a;
		logic [6:0] wv, cur, mx, nxt, v;
		short_ev = 1'b0;
		long_ev = 1'b0;
		wr = 1'b0;
		wa = 5'h00;
		wv = 7'h00;
		a = ch_addr(st.sel);
		cur = rdata;
		mx = max_of(a);
		nxt = 7'h00;
		v = 7'h00;
		step = 1'b0;
		cw = 1'b0;
		next_st = st;
		next_st.nv_rd = 1'b0;
		next_st.nv_we = 1'b0;
		next_st.ram_we = 1'b0;
		next_st.gain_we = 1'b0;
		// pins pass two flops before use
		next_st.a1 = enc_a_pin;
		next_st.a2 = st.a1;
		next_st.ap = st.a2;
		next_st.b1 = enc_b_pin;
		next_st.b2 = st.b1;
		next_st.p1 = enc_push_pin;
		next_st.p2 = st.p1;
		step = st.a2 && !st.ap; // one detent per rising phase a
		cw = !st.b2;
		// debounce: the new level must hold for the whole settle time
		if (st.p2 != st.btn)
		begin
			next_st.db_cnt = 27'(st.db_cnt + 27'h1);
			if (st.db_cnt == 27'(DEBOUNCE_CYC - 1))
			begin
				next_st.btn = st.p2;
				next_st.db_cnt = 27'h0;
				if (st.p2)
				begin
					next_st.hold = 27'h0;
					next_st.long_done = 1'b0;
				end
				else
					short_ev = !st.long_done; // release after a long press does nothing
			end
		end
		else
			next_st.db_cnt = 27'h0;
		// long action fires while still held, once per press
		if (st.btn && !st.long_done)
		begin
			next_st.hold = 27'(st.hold + 27'h1);
			if (st.hold == 27'(LONG_CYC - 1))
			begin
				long_ev = 1'b1;
				next_st.long_done = 1'b1;
			end
		end
		// midi byte sequencer, advances on each accepted byte
		if (st.midi_valid && midi_ready)
		begin
			case (st.midi_cnt)
				2'h3:
				begin
					next_st.midi_byte = st.midi_note;
					next_st.midi_cnt = 2'h2;
				end
				2'h2:
				begin
					next_st.midi_byte = FPE_NOTE_VEL;
					next_st.midi_cnt = 2'h1;
				end
				default:
				begin
					next_st.midi_valid = 1'b0;
					next_st.midi_cnt = 2'h0;
				end
			endcase
		end
		case (st.state)
			FPE_LOAD:
			begin
				if (st.cnt <= FPE_NV_LAST)
				begin
					next_st.nv_rd = 1'b1;
					next_st.nv_addr = st.cnt;
					next_st.cnt = 5'(st.cnt + 5'h01);
				end
				next_st.rd_d = st.nv_rd;
				next_st.cnt_d = st.nv_addr;
				if (st.rd_d)
				begin
					if (st.cnt_d == FPE_NV_CFG)
					begin
						next_st.cfg0 = nv_rdata;
						next_st.gang = nv_rdata[FPE_CFG_GANG_BIT];
					end
					else if (st.cnt_d == FPE_NV_IO)
						next_st.cfg_io = nv_rdata;
					else
					begin
						wr = 1'b1; // applied to preamps and mixer as it arrives
						wa = 5'(st.cnt_d - FPE_NV_CH_BASE);
						wv = nv_rdata[6:0];
					end
					if (st.cnt_d == FPE_NV_LAST)
						next_st.state = FPE_RUN;
				end
			end
			FPE_STORE:
			begin
				next_st.rd_d = (st.cnt <= FPE_NV_LAST);
				next_st.cnt_d = st.cnt;
				if (st.cnt <= FPE_NV_LAST)
					next_st.cnt = 5'(st.cnt + 5'h01);
				if (st.rd_d)
				begin
					next_st.nv_we = 1'b1;
					next_st.nv_addr = st.cnt_d;
					if (st.cnt_d == FPE_NV_CFG)
						next_st.nv_wdata = st.cfg0;
					else if (st.cnt_d == FPE_NV_IO)
						next_st.nv_wdata = st.cfg_io;
					else
						next_st.nv_wdata = {1'b0, rdata};
					if (st.cnt_d == FPE_NV_LAST)
						next_st.state = FPE_RUN;
				end
			end
			default:
			begin
				if (st.pend)
				begin
					wr = 1'b1;
					wa = 5'(st.sel + 5'h01);
					wv = st.pend_val;
					next_st.pend = 1'b0;
				end
				else if (host_inst_we)
				begin
					wr = 1'b1;
					wa = FPE_INST_IDX;
					wv = host_inst_val;
				end
				else if (store_req)
				begin
					// the saved midi flag decides whether controller mode stays on
					next_st.cfg0[FPE_CFG_MIDI_BIT] = store_midi_en;
					next_st.cfg0[FPE_CFG_GANG_BIT] = st.gang;
					next_st.state = FPE_STORE;
					next_st.cnt = 5'h00;
					next_st.rd_d = 1'b0;
				end
				else if (step && st.cfg0[FPE_CFG_MIDI_BIT])
				begin
					// a step while a message is still going out is dropped
					if (st.midi_cnt == 2'h0)
					begin
						next_st.midi_cnt = 2'h3;
						next_st.midi_valid = 1'b1;
						next_st.midi_byte = FPE_NOTE_ON;
						next_st.midi_note = cw ? FPE_NOTE_CW : FPE_NOTE_CCW;
					end
				end
				else if (step && st.level_mode)
				begin
					if (cw)
						nxt = (cur >= mx) ? mx : 7'(cur + 7'h01);
					else
						nxt = (cur == 7'h00) ? 7'h00 : 7'(cur - 7'h01);
					wr = 1'b1;
					wa = a;
					wv = nxt;
					next_st.gang_show = 1'b0;
					if (st.gang && has_partner(st.sel))
					begin
						next_st.pend = 1'b1;
						next_st.pend_val = nxt;
					end
				end
				else if (step)
				begin
					next_st.sel = next_ch(st.sel, cw, st.gang);
					next_st.gang_show = 1'b0;
				end
				if (short_ev)
				begin
					next_st.level_mode = !st.level_mode;
					next_st.gang_show = 1'b0;
				end
				if (long_ev)
				begin
					next_st.gang = !st.gang;
					next_st.gang_show = 1'b1;
					if (!st.gang && st.sel[0] && st.sel != FPE_COAX_SEL)
						next_st.sel = 5'(st.sel - 5'h01);
				end
			end
		endcase
		// one write path to the store, the mixer and the analog gains
		if (wr)
		begin
			wv = (wv > max_of(wa)) ? max_of(wa) : wv;
			next_st.ram_we = 1'b1;
			next_st.ram_waddr = wa;
			next_st.ram_wdata = wv;
			next_st.gain_we = 1'b1;
			next_st.gain_idx = wa;
			next_st.gain_val = wv;
			if (wa == 5'h00)
				next_st.mic1 = wv;
			else if (wa == 5'h01)
				next_st.mic2 = wv;
			else if (wa == FPE_INST_IDX)
				next_st.inst = wv;
		end
		// display
		next_st.dot_hi = 1'b0;
		next_st.dot_lo = 1'b0;
		if (st.state != FPE_RUN)
		begin
			next_st.ch_hi = FPE_CHAR_DASH;
			next_st.ch_lo = FPE_CHAR_DASH;
		end
		else if (st.gang_show)
		begin
			next_st.ch_hi = FPE_CHAR_O;
			next_st.ch_lo = st.gang ? FPE_CHAR_N : FPE_CHAR_F;
		end
		else if (!st.level_mode)
		begin
			next_st.dot_hi = 1'b1;
			if (st.sel < FPE_LINE_FIRST)
				{next_st.ch_hi, next_st.ch_lo} = {FPE_CHAR_IN, dig(7'(st.sel + 5'h01))};
			else if (st.sel < FPE_PHONES_SEL)
				{next_st.ch_hi, next_st.ch_lo} = {FPE_CHAR_LINE, dig(7'(st.sel - 5'h03))};
			else if (st.sel >= FPE_OPT_FIRST)
				{next_st.ch_hi, next_st.ch_lo} = {FPE_CHAR_OPT, dig(7'(st.sel - 5'h0b))};
			else
			begin
				next_st.dot_hi = 1'b0;
				{next_st.ch_hi, next_st.ch_lo} = (st.sel == FPE_PHONES_SEL) ?
					FPE_HEADPHONE_PAIR_LABEL : FPE_COAX_DIGITAL_OUT_LABEL;
			end
		end
		else
		begin
			// level mode: magnitude in dB, left dot marks a negative level
			if (a < FPE_INST_IDX)
				v = (cur == 7'h00) ? 7'h00 : 7'(cur + FPE_MIC_OFS_DB);
			else if (a < FPE_LINE_FIRST)
			begin
				v = {1'b0, cur[6:1]};
				next_st.dot_lo = cur[0];
			end
			else if (cur >= FPE_OUT_ZERO)
				v = 7'(cur - FPE_OUT_ZERO);
			else
			begin
				v = 7'(FPE_OUT_ZERO - cur);
				next_st.dot_hi = 1'b1;
			end
			next_st.ch_hi = dig(7'(v / 7'd10));
			next_st.ch_lo = dig(7'(v % 7'd10));
			if (a >= FPE_LINE_FIRST && cur == 7'h00)
				{next_st.ch_hi, next_st.ch_lo} = {FPE_CHAR_DASH, FPE_CHAR_DASH};
		end
	end

	// state register
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			st <= '0;
			st.state <= FPE_LOAD;
			st.cfg0 <= FPE_CFG_RESET;
		end
		else
			st <= next_st;
	end

	assign nv_rd = st.nv_rd;
	assign nv_we = st.nv_we;
	assign nv_addr = st.nv_addr;
	assign nv_wdata = st.nv_wdata;
	assign mode_led = st.level_mode;
	assign disp_char_hi = st.ch_hi;
	assign disp_char_lo = st.ch_lo;
	assign disp_dot_hi = st.dot_hi;
	assign disp_dot_lo = st.dot_lo;
	assign mic_gain_1 = st.mic1;
	assign mic_gain_2 = st.mic2;
	assign inst_gain = st.inst;
	assign gain_we = st.gain_we;
	assign gain_idx = st.gain_idx;
	assign gain_val = st.gain_val;
	assign cfg_rate = st.cfg0[2:0];
	assign cfg_master = st.cfg0[FPE_CFG_MASTER_BIT];
	assign cfg_io = st.cfg_io;
	assign gang_on = st.gang;
	assign midi_valid = st.midi_valid;
	assign midi_byte = st.midi_byte;

	a_boot_reads_memory: assert property (@(posedge ref_clk) disable iff (reset)
		$fell(reset) |-> ##[0:2] nv_rd)
		else $error("no memory read after reset release");
	a_short_flips_mode: assert property (@(posedge ref_clk) disable iff (reset)
		(st.btn && !st.p2 && st.state == FPE_RUN && !st.long_done &&
		st.db_cnt == 27'(DEBOUNCE_CYC - 1)) |=> (mode_led != $past(mode_led)))
		else $error("short press did not toggle the mode led");
	a_long_flips_gang: assert property (@(posedge ref_clk) disable iff (reset)
		(st.btn && !st.long_done && st.state == FPE_RUN &&
		st.hold == 27'(LONG_CYC - 1)) |=> (gang_on != $past(gang_on)) ##1 disp_char_hi == FPE_CHAR_O)
		else $error("long press did not toggle gang or show it");
	a_mic_range: assert property (@(posedge ref_clk) disable iff (reset)
		(gain_we && gain_idx < FPE_INST_IDX) |-> gain_val <= FPE_MIC_MAX)
		else $error("mic gain code out of range");
	a_inst_range: assert property (@(posedge ref_clk) disable iff (reset)
		(gain_we && gain_idx == FPE_INST_IDX) |-> inst_gain <= FPE_INST_MAX)
		else $error("instrument gain code out of range");
	a_out_range: assert property (@(posedge ref_clk) disable iff (reset)
		(gain_we && gain_idx >= FPE_LINE_FIRST) |-> gain_val <= FPE_OUT_MAX)
		else $error("output level code out of range");
	a_gang_left_only: assert property (@(posedge ref_clk) disable iff (reset)
		gang_on && st.state == FPE_RUN |-> (!st.sel[0] || st.sel == FPE_COAX_SEL))
		else $error("right channel selected in gang mode");
	a_host_inst_write: assert property (@(posedge ref_clk) disable iff (reset)
		(host_inst_we && !st.pend && st.state == FPE_RUN) |=>
		gain_we && gain_idx == FPE_INST_IDX && inst_gain == gain_val)
		else $error("host instrument gain not applied");
	a_midi_message: assert property (@(posedge ref_clk) disable iff (reset)
		(midi_valid && midi_byte == FPE_NOTE_ON && midi_ready) |=>
		midi_valid && (midi_byte == FPE_NOTE_CW || midi_byte == FPE_NOTE_CCW))
		else $error("note byte did not follow note-on status");
endmodule : fpe_front_panel

// ---- verilog/fpe_param_ram.sv ----
`timescale 1ns/100ps
// small parameter store, one write and one registered read port
module fpe_param_ram
	import fpe_pkg::*;
(
	input wire logic ref_clk, // system clock
	input wire logic we, // write strobe
	input wire logic [4:0] waddr, // write slot
	input wire logic [6:0] wdata, // gain code to store
	input wire logic [4:0] raddr, // read slot
	output logic [6:0] rdata // registered read data
);
	logic [6:0] mem [0:31]; // one gain code per channel entry

	// write first in source order, read returns the old word on a collision
	always_ff @(posedge ref_clk)
	begin
		if (we)
		begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule : fpe_param_ram

// ---- verilog/fpe_pkg.sv ----
package fpe_pkg;
	// channel list: 4 inputs, 6 line outs, phones pair, coax, 8 optical
	localparam logic [4:0] FPE_CH_LAST = 5'h13; // last channel select index
	localparam logic [4:0] FPE_LINE_FIRST = 5'h04; // first line output
	localparam logic [4:0] FPE_PHONES_SEL = 5'h0a; // phones pair entry
	localparam logic [4:0] FPE_COAX_SEL = 5'h0b; // coax output entry
	localparam logic [4:0] FPE_OPT_FIRST = 5'h0c; // first optical output
	localparam logic [4:0] FPE_INST_IDX = 5'h02; // shared instrument gain slot
	localparam logic [4:0] FPE_INST_ALT = 5'h03; // second instrument entry
	// non-volatile image layout
	localparam logic [4:0] FPE_NV_CFG = 5'h00; // rate, clock master, midi, gang
	localparam logic [4:0] FPE_NV_IO = 5'h01; // channel and digital i/o setup
	localparam logic [4:0] FPE_NV_CH_BASE = 5'h02; // first channel parameter word
	localparam logic [4:0] FPE_NV_LAST = 5'h15; // last word of the image
	// fields of the configuration word
	localparam int FPE_CFG_MASTER_BIT = 3; // clock master when set
	localparam int FPE_CFG_MIDI_BIT = 4; // encoder acts as midi controller
	localparam int FPE_CFG_GANG_BIT = 5; // stereo gang mode
	localparam logic [7:0] FPE_CFG_RESET = 8'h00; // configuration before load
	// gain codes: mic 0=0dB, n=n+9 dB; inst n=n/2 dB; out 0=mute, n=n-59 dB
	localparam logic [6:0] FPE_MIC_MAX = 7'h38; // 65 dB
	localparam logic [6:0] FPE_MIC_OFS_DB = 7'h09; // code to dB offset
	localparam logic [6:0] FPE_INST_MAX = 7'h24; // 18 dB
	localparam logic [6:0] FPE_OUT_MAX = 7'h41; // +6 dB
	localparam logic [6:0] FPE_OUT_ZERO = 7'h3b; // code of 0 dB
	// midi note messages
	localparam logic [7:0] FPE_NOTE_ON = 8'h90; // note on, channel 1
	localparam logic [7:0] FPE_NOTE_CW = 8'h61; // note sent for a clockwise step
	localparam logic [7:0] FPE_NOTE_CCW = 8'h60; // note sent for a counter step
	localparam logic [7:0] FPE_NOTE_VEL = 8'h7f; // velocity byte
	// display characters
	localparam logic [7:0] FPE_CHAR_IN = 8'h69; // i
	localparam logic [7:0] FPE_CHAR_LINE = 8'h4c; // L
	localparam logic [7:0] FPE_CHAR_OPT = 8'h41; // A
	localparam logic [7:0] FPE_CHAR_O = 8'h6f; // o
	localparam logic [7:0] FPE_CHAR_F = 8'h66; // f
	localparam logic [7:0] FPE_CHAR_N = 8'h6e; // n
	localparam logic [7:0] FPE_CHAR_DASH = 8'h2d; // -
	localparam logic [7:0] FPE_CHAR_ZERO = 8'h30; // 0
	localparam logic [15:0] FPE_HEADPHONE_PAIR_LABEL = 16'h5048; // phones label
	localparam logic [15:0] FPE_COAX_DIGITAL_OUT_LABEL = 16'h5350; // coax label
	// timing
	localparam int FPE_CLK_KHZ = 100000; // ref_clk rate
	localparam int FPE_DEBOUNCE_MS = 10; // button must be stable this long
	localparam int FPE_LONG_MS = 1000; // hold time of a long press
	localparam int FPE_DEBOUNCE_CYC = FPE_DEBOUNCE_MS * FPE_CLK_KHZ; // cycles
	localparam int FPE_LONG_CYC = FPE_LONG_MS * FPE_CLK_KHZ; // cycles
	// control states
	typedef enum logic [2:0] {
		FPE_LOAD = 3'b001,
		FPE_RUN = 3'b010,
		FPE_STORE = 3'b100
	} fpe_state_t;
endpackage : fpe_pkg
